// *** core/pcr_map.svh ***
// Offsets, field positions and reset values of the port capability registers
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

`define PCR_OFF_CAP_HDR      8'hc0
`define PCR_OFF_DEV_CAP      8'hc4

`define PCR_CAP_ID           8'h10
`define PCR_NEXT_PTR         8'h00
`define PCR_CAP_VER          4'h2
`define PCR_TYPE_UP          4'h5
`define PCR_TYPE_DN          4'h6
`define PCR_MSG_NUM          5'h00

`define PCR_PL_128           3'h0
`define PCR_PL_256           3'h1
`define PCR_PL_512           3'h2
`define PCR_PHANTOM          2'h0
`define PCR_EXT_TAG          1'h0
`define PCR_LAT_L0S          3'h0
`define PCR_LAT_L1           3'h0
`define PCR_RBER_RST         1'h1
`define PCR_SPL_VAL_RST      8'h00
`define PCR_SPL_SCL_RST      2'h0

`define PCR_HDR_SLOT_BIT     24
`define PCR_CAP_PL_LSB       0
`define PCR_CAP_RBER_BIT     15
`define PCR_CAP_SPLV_LSB     18
`define PCR_CAP_SPLS_LSB     26

`endif

// *** core/pcr_pkg.sv ***
// Types shared by the port capability register files
package pcr_pkg;
	typedef enum logic [1:0] {
		PCR_ST_RESET = 2'b01,
		PCR_ST_RUN   = 2'b10
	} pcr_state_t;
	typedef logic [31:0] pcr_word_t;
endpackage

// *** core/pcr_sync.sv ***
// Three-stage pin synchroniser with agreement check
`timescale 1ns/10ps
`default_nettype none
module pcr_sync (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic pin_in,
	output var  logic level_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			lvl_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				lvl_ff <= s3_ff;
			end
		end
	end
	assign level_out = lvl_ff;
endmodule
`default_nettype wire

// *** core/pcr_spl_capture.sv ***
// Slot power limit capture for the upstream port
`timescale 1ns/10ps
`default_nettype none
`include "pcr_map.svh"
module pcr_spl_capture
	import pcr_pkg::*;
#(
	parameter bit IS_UPSTREAM = 1'b1
) (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       msg_valid_in,
	input  wire logic [7:0] msg_value_in,
	input  wire logic [1:0] msg_scale_in,
	output var  logic [7:0] value_out,
	output var  logic [1:0] scale_out
);
	logic [7:0] value_ff;
	logic [1:0] scale_ff;
	wire        take_msg = IS_UPSTREAM && msg_valid_in;
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			value_ff <= `PCR_SPL_VAL_RST;
			scale_ff <= `PCR_SPL_SCL_RST;
		end else if (take_msg) begin
			value_ff <= msg_value_in;
			scale_ff <= msg_scale_in;
		end
	end
	assign value_out = value_ff;
	assign scale_out = scale_ff;
endmodule
`default_nettype wire

// *** core/pcr_port_cap_regs.sv ***
// Capability header and device capabilities registers of one switch port
//
// Overview of operation
// R1: Header low byte always reads capability identifier 10h.
// R2: Next-capability pointer byte always reads zero.
// R3: Capability version field reads 2.
// R4: Port type resets to 0101b upstream, 0110b downstream.
// R5: Slot-present resets 1 downstream, 0 upstream; loader may override downstream only.
// R6: Interrupt message number field reads zero.
// R7: Payload codes: 000b 128, 001b 256, 010b 512 bytes; others reserved.
// R8: Payload field resets 001b with strap low, 010b with strap high.
// R9: Payloads up to 512 bytes; loader may override the payload field.
// R10: Phantom functions field always reads 00b.
// R11: Extended tag supported bit always reads zero.
// R12: L0s and L1 acceptable latency fields reset 000b, read-only.
// R13: Role-based error reporting resets 1; loader may override.
// R14: Upstream only: slot power value resets 00h, set by message.
// R15: Upstream only: slot power scale resets 00b, set by message.
// R16: Configuration writes ignored; reserved bits read zero.
// R17: Loader overrides use a private write path past read-only.
`timescale 1ns/10ps
`default_nettype none
`include "pcr_map.svh"
module pcr_port_cap_regs
	import pcr_pkg::*;
#(
	parameter bit IS_UPSTREAM = 1'b1
) (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        payload_size_strap_in,
	input  wire logic        cfg_rd_in,
	input  wire logic        cfg_wr_in,
	input  wire logic [7:0]  cfg_addr_in,
	input  wire logic [31:0] cfg_wdata_in,
	output var  logic [31:0] cfg_rdata_out,
	output var  logic        cfg_rvalid_out,
	input  wire logic        ld_wr_in,
	input  wire logic [7:0]  ld_addr_in,
	input  wire logic [31:0] ld_wdata_in,
	input  wire logic        spl_msg_valid_in,
	input  wire logic [7:0]  spl_msg_value_in,
	input  wire logic [1:0]  spl_msg_scale_in,
	output var  logic [2:0]  max_payload_out
);
	////////////////////////////////////////////////////////////////////////
	logic       strap_lvl;
	logic [7:0] spl_value;
	logic [1:0] spl_scale;

	pcr_sync u_strap_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.pin_in    (payload_size_strap_in),
		.level_out (strap_lvl)
	);

	// R14: value captured from message
	pcr_spl_capture #(
		.IS_UPSTREAM (IS_UPSTREAM)
	) u_spl (
		.clk_in       (clk_in),
		.resetn_in    (resetn_in),
		.msg_valid_in (spl_msg_valid_in),
		.msg_value_in (spl_msg_value_in),
		.msg_scale_in (spl_msg_scale_in),
		.value_out    (spl_value),
		.scale_out    (spl_scale)
	);

	////////////////////////////////////////////////////////////////////////
	// Strap is caught after release, once synchroniser has settled
	pcr_state_t state_ff;
	pcr_state_t nxt_state;
	logic [2:0] settle_ff;
	logic [2:0] nxt_settle;
	logic       slot_ff;
	logic [2:0] pl_ff;
	logic       rber_ff;
	logic [2:0] nxt_pl;
	logic       nxt_slot;
	logic       nxt_rber;
	logic [31:0] rdata_ff;
	logic        rvalid_ff;
	logic [2:0]  mps_ff;

	wire settled   = (settle_ff == 3'h4);
	wire ld_hdr    = ld_wr_in && (ld_addr_in == `PCR_OFF_CAP_HDR);
	wire ld_cap    = ld_wr_in && (ld_addr_in == `PCR_OFF_DEV_CAP);
	wire [2:0] ld_pl = ld_wdata_in[`PCR_CAP_PL_LSB +: 3];
	// R7: reserved payload codes refused by loader
	wire ld_pl_ok  = (ld_pl == `PCR_PL_128) || (ld_pl == `PCR_PL_256) ||
		(ld_pl == `PCR_PL_512);
	// R8: strap selects default payload
	wire [2:0] strap_pl = strap_lvl ? `PCR_PL_512 : `PCR_PL_256;
	wire strap_take = (state_ff == PCR_ST_RESET) && settled;

	always_comb begin
		nxt_state  = state_ff;
		nxt_settle = settle_ff;
		nxt_pl     = pl_ff;
		nxt_slot   = slot_ff;
		nxt_rber   = rber_ff;
		unique case (state_ff)
			PCR_ST_RESET: begin
				if (settled) begin
					nxt_state = PCR_ST_RUN;
					nxt_pl    = strap_pl;
				end else begin
					nxt_settle = settle_ff + 3'h1;
				end
			end
			PCR_ST_RUN: begin
			end
			default: begin
				nxt_state = PCR_ST_RESET;
			end
		endcase
		// R17: loader bypasses read-only protection
		if (ld_hdr && !IS_UPSTREAM) begin
			nxt_slot = ld_wdata_in[`PCR_HDR_SLOT_BIT];
		end
		// R9: loader override of payload
		if (ld_cap && ld_pl_ok && !strap_take) begin
			nxt_pl = ld_pl;
		end
		// R13: loader override of error reporting
		if (ld_cap) begin
			nxt_rber = ld_wdata_in[`PCR_CAP_RBER_BIT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_ff  <= PCR_ST_RESET;
			settle_ff <= 3'h0;
			// R5: slot default by port role
			slot_ff   <= IS_UPSTREAM ? 1'b0 : 1'b1;
			pl_ff     <= `PCR_PL_256;
			// R13: role-based reporting supported
			rber_ff   <= `PCR_RBER_RST;
		end else begin
			state_ff  <= nxt_state;
			settle_ff <= nxt_settle;
			slot_ff   <= nxt_slot;
			pl_ff     <= nxt_pl;
			rber_ff   <= nxt_rber;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// R4: port type by role
	wire [3:0] port_type = IS_UPSTREAM ? `PCR_TYPE_UP : `PCR_TYPE_DN;

	// R1: identifier; R2: next pointer; R3: version; R6: message number
	wire [31:0] hdr_word = {2'h0, `PCR_MSG_NUM, slot_ff, port_type,
		`PCR_CAP_VER, `PCR_NEXT_PTR, `PCR_CAP_ID};

	// R10: phantom; R11: ext tag; R12: latencies; R15: scale
	wire [31:0] cap_word = {4'h0, spl_scale, spl_value, 2'h0, rber_ff,
		3'h0, `PCR_LAT_L1, `PCR_LAT_L0S, `PCR_EXT_TAG, `PCR_PHANTOM, pl_ff};

	// R16: unmapped and reserved read as zero
	wire [31:0] rd_word = (cfg_addr_in == `PCR_OFF_CAP_HDR) ? hdr_word :
		(cfg_addr_in == `PCR_OFF_DEV_CAP) ? cap_word : 32'h0000_0000;

	// R16: configuration writes have no path into the registers
	wire cfg_wr_unused = cfg_wr_in & (|cfg_wdata_in);

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rdata_ff  <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
			mps_ff    <= `PCR_PL_256;
		end else begin
			rvalid_ff <= cfg_rd_in;
			rdata_ff  <= cfg_rd_in ? rd_word : 32'h0000_0000;
			mps_ff    <= pl_ff;
		end
	end

	assign cfg_rdata_out   = rdata_ff;
	assign cfg_rvalid_out  = rvalid_ff;
	assign max_payload_out = mps_ff;

	////////////////////////////////////////////////////////////////////////
	sequence s_rd_hdr;
		cfg_rd_in && cfg_addr_in == `PCR_OFF_CAP_HDR;
	endsequence
	sequence s_rd_cap;
		cfg_rd_in && cfg_addr_in == `PCR_OFF_DEV_CAP;
	endsequence

	property p_cap_id;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_hdr |=> cfg_rvalid_out && cfg_rdata_out[15:0] == 16'h0010;
	endproperty
	a_cap_id: assert property (p_cap_id) else $error("bad id/pointer"); // R1
	property p_ver_type;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_hdr |=> cfg_rdata_out[23:16] ==
			{(IS_UPSTREAM ? 4'h5 : 4'h6), 4'h2};
	endproperty
	a_ver_type: assert property (p_ver_type) else $error("bad type"); // R4
	property p_hdr_rsvd;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_hdr |=> cfg_rdata_out[31:25] == 7'h00;
	endproperty
	a_hdr_rsvd: assert property (p_hdr_rsvd) else $error("hdr high set"); // R6
	property p_cap_fixed;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_cap |=> cfg_rdata_out[14:3] == 12'h000 &&
			cfg_rdata_out[31:28] == 4'h0 && cfg_rdata_out[17:16] == 2'h0;
	endproperty
	a_cap_fixed: assert property (p_cap_fixed) else $error("fixed bits"); // R10
	property p_pl_legal;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_cap |=> cfg_rdata_out[2:0] <= 3'h2;
	endproperty
	a_pl_legal: assert property (p_pl_legal) else $error("bad payload"); // R7
	property p_strap;
		@(posedge clk_in) disable iff (!resetn_in)
		strap_take && !ld_cap |=> pl_ff == ($past(strap_lvl) ? 3'h2 : 3'h1);
	endproperty
	a_strap: assert property (p_strap) else $error("strap ignored"); // R8
	property p_spl;
		@(posedge clk_in) disable iff (!resetn_in)
		spl_msg_valid_in && IS_UPSTREAM |=>
			spl_value == $past(spl_msg_value_in);
	endproperty
	a_spl: assert property (p_spl) else $error("spl not captured"); // R14
	property p_spl_dn;
		@(posedge clk_in) disable iff (!resetn_in)
		!IS_UPSTREAM |-> spl_scale == 2'h0 && spl_value == 8'h00;
	endproperty
	a_spl_dn: assert property (p_spl_dn) else $error("spl downstream"); // R15
	property p_wr_ign;
		@(posedge clk_in) disable iff (!resetn_in)
		cfg_wr_in && !ld_wr_in && state_ff == PCR_ST_RUN |=>
			$stable(pl_ff) && $stable(rber_ff) && $stable(slot_ff);
	endproperty
	a_wr_ign: assert property (p_wr_ign) else $error("cfg write took"); // R16
	property p_ld_rber;
		@(posedge clk_in) disable iff (!resetn_in)
		ld_cap |=> rber_ff == $past(ld_wdata_in[15]);
	endproperty
	a_ld_rber: assert property (p_ld_rber) else $error("load lost"); // R17

	// Loader steps: legal code, reserved code, slot bit; then a read of an unmapped offset
	sequence s_ld_pl_good;
		ld_cap && ld_pl_ok && !strap_take;
	endsequence
	sequence s_ld_pl_bad;
		ld_cap && !ld_pl_ok && !strap_take;
	endsequence
	sequence s_ld_slot;
		ld_hdr && !IS_UPSTREAM;
	endsequence
	sequence s_rd_other;
		cfg_rd_in && cfg_addr_in != `PCR_OFF_CAP_HDR &&
			cfg_addr_in != `PCR_OFF_DEV_CAP;
	endsequence

	property p_ld_pl;
		@(posedge clk_in) disable iff (!resetn_in)
		s_ld_pl_good |=> pl_ff == $past(ld_pl);
	endproperty
	a_ld_pl: assert property (p_ld_pl) else $error("pl load lost"); // R9
	property p_ld_pl_bad;
		@(posedge clk_in) disable iff (!resetn_in)
		s_ld_pl_bad |=> $stable(pl_ff);
	endproperty
	a_ld_pl_bad: assert property (p_ld_pl_bad) else $error("pl rsvd"); // R7
	property p_ld_slot;
		@(posedge clk_in) disable iff (!resetn_in)
		s_ld_slot |=> slot_ff == $past(ld_wdata_in[`PCR_HDR_SLOT_BIT]);
	endproperty
	a_ld_slot: assert property (p_ld_slot) else $error("slot lost"); // R17
	property p_slot_up;
		@(posedge clk_in) disable iff (!resetn_in)
		IS_UPSTREAM |-> !slot_ff;
	endproperty
	a_slot_up: assert property (p_slot_up) else $error("slot up set"); // R5
	property p_slot_rd;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_hdr |=> cfg_rdata_out[`PCR_HDR_SLOT_BIT] == $past(slot_ff);
	endproperty
	a_slot_rd: assert property (p_slot_rd) else $error("slot read"); // R5
	property p_rber_rd;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_cap |=> cfg_rdata_out[`PCR_CAP_RBER_BIT] == $past(rber_ff);
	endproperty
	a_rber_rd: assert property (p_rber_rd) else $error("rber read"); // R13
	property p_spl_rd;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_cap |=> cfg_rdata_out[27:18] == $past({spl_scale, spl_value});
	endproperty
	a_spl_rd: assert property (p_spl_rd) else $error("spl read"); // R14
	property p_spl_scl;
		@(posedge clk_in) disable iff (!resetn_in)
		spl_msg_valid_in && IS_UPSTREAM |=>
			spl_scale == $past(spl_msg_scale_in);
	endproperty
	a_spl_scl: assert property (p_spl_scl) else $error("scale lost"); // R15
	property p_mps;
		@(posedge clk_in) disable iff (!resetn_in)
		1'b1 |=> max_payload_out == $past(pl_ff);
	endproperty
	a_mps: assert property (p_mps) else $error("payload copy"); // R9
	property p_rd_idle;
		@(posedge clk_in) disable iff (!resetn_in)
		!cfg_rd_in |=> !cfg_rvalid_out && cfg_rdata_out == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("idle data"); // R16
	property p_rd_other;
		@(posedge clk_in) disable iff (!resetn_in)
		s_rd_other |=> cfg_rdata_out == 32'h0000_0000;
	endproperty
	a_rd_other: assert property (p_rd_other) else $error("unmapped"); // R16
endmodule
`default_nettype wire

// *** verif/pcr_host_model.sv ***
// Host configuration software model on the config port
`timescale 1ns/10ps
`default_nettype none
module pcr_host_model (
	input  wire logic        clk_in,
	output var  logic        cfg_rd_out,
	output var  logic        cfg_wr_out,
	output var  logic [7:0]  cfg_addr_out,
	output var  logic [31:0] cfg_wdata_out
);
	initial begin
		cfg_rd_out = 1'b0;
		cfg_wr_out = 1'b0;
		cfg_addr_out = 8'h00;
		cfg_wdata_out = 32'h0000_0000;
	end
	// One access per call, held across the taking edge
	task automatic access(input logic wr, input logic [7:0] addr,
		input logic [31:0] data);
		@(posedge clk_in);
		#1;
		cfg_rd_out = ~wr;
		cfg_wr_out = wr;
		cfg_addr_out = addr;
		cfg_wdata_out = data;
		@(posedge clk_in);
		#1;
		cfg_rd_out = 1'b0;
		cfg_wr_out = 1'b0;
		// Idle bus inverted so stale values never look valid
		cfg_addr_out = ~addr;
		cfg_wdata_out = ~data;
	endtask
endmodule
`default_nettype wire

// *** verif/pcr_port_cap_regs_bench.sv ***
// Self-checking bench for the port capability registers
`timescale 1ns/10ps
`default_nettype none
module pcr_port_cap_regs_bench;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        strap = 1'b0;
	logic        rd, wr, ld_wr = 1'b0, spl_v = 1'b0;
	logic [7:0]  addr, ld_addr = 8'h00, spl_val = 8'h00;
	logic [1:0]  spl_scl = 2'h0;
	logic [31:0] wdata, ld_data = 32'h0000_0000, rdata, hdr_exp, cap_exp;
	logic        rvalid;
	logic [2:0]  max_pl;
	logic [2:0]  max_pl_dn;
	logic [31:0] rdata_dn;
	logic        rvalid_dn;
	logic        slot_dn = 1'b1;
	logic [31:0] exp_dn_q[$];
	logic [31:0] exp_q[$];
	int          n_fail = 0, n_checks = 0, seed = 66967;

	always #5 clk_in = ~clk_in;

	pcr_host_model i_pcr_host_model (.clk_in(clk_in), .cfg_rd_out(rd),
		.cfg_wr_out(wr), .cfg_addr_out(addr), .cfg_wdata_out(wdata));

	pcr_port_cap_regs #(.IS_UPSTREAM(1'b1)) i_pcr_port_cap_regs (
		.clk_in(clk_in), .resetn_in(resetn_in),
		.payload_size_strap_in(strap), .cfg_rd_in(rd), .cfg_wr_in(wr),
		.cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
		.cfg_rvalid_out(rvalid), .ld_wr_in(ld_wr), .ld_addr_in(ld_addr),
		.ld_wdata_in(ld_data), .spl_msg_valid_in(spl_v),
		.spl_msg_value_in(spl_val), .spl_msg_scale_in(spl_scl),
		.max_payload_out(max_pl));

	// Downstream copy sees the same traffic
	pcr_port_cap_regs #(.IS_UPSTREAM(1'b0)) i_pcr_port_cap_regs_dn (
		.clk_in(clk_in), .resetn_in(resetn_in),
		.payload_size_strap_in(strap), .cfg_rd_in(rd), .cfg_wr_in(wr),
		.cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata_dn),
		.cfg_rvalid_out(rvalid_dn), .ld_wr_in(ld_wr), .ld_addr_in(ld_addr),
		.ld_wdata_in(ld_data), .spl_msg_valid_in(spl_v),
		.spl_msg_value_in(spl_val), .spl_msg_scale_in(spl_scl),
		.max_payload_out(max_pl_dn));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] dn;
		// Downstream: own type and slot, no slot power capture
		dn = exp;
		if (a == 8'hc0)
			dn[24:20] = {slot_dn, 4'h6};
		else if (a == 8'hc4)
			dn[27:18] = 10'h000;
		exp_q.push_back(exp);
		exp_dn_q.push_back(dn);
		i_pcr_host_model.access(1'b0, a, 32'h0000_0000);
	endtask

	task automatic ld(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		#1;
		ld_wr = 1'b1;
		ld_addr = a;
		ld_data = d;
		@(posedge clk_in);
		#1;
		ld_wr = 1'b0;
		ld_data = ~d;
	endtask

	// Monitor pops the oldest note on every answer
	always @(negedge clk_in) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0)
				chk(rdata, 32'hxxxx_xxxx);
			else
				chk(rdata, exp_q.pop_front());
		end
		if (rvalid_dn === 1'b1) begin
			if (exp_dn_q.size() == 0)
				chk(rdata_dn, 32'hxxxx_xxxx);
			else
				chk(rdata_dn, exp_dn_q.pop_front());
		end
	end

	initial begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial begin
		logic [31:0] r;
		r = $random(seed);
		strap = r[0];
		repeat (12) @(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		repeat (8) @(posedge clk_in);
		// Upstream identity, type and slot absent
		hdr_exp = 32'h0052_0010;
		cap_exp = {16'h0000, 16'h8000} | (strap ? 32'h2 : 32'h1);
		rd_chk(8'hc0, hdr_exp);
		rd_chk(8'hc4, cap_exp);
		chk({29'h0, max_pl}, {29'h0, cap_exp[2:0]});
		chk({29'h0, max_pl_dn}, {29'h0, cap_exp[2:0]});
		// Config writes never land
		i_pcr_host_model.access(1'b1, 8'hc0, $random(seed));
		i_pcr_host_model.access(1'b1, 8'hc4, $random(seed));
		rd_chk(8'hc0, hdr_exp);
		rd_chk(8'hc4, cap_exp);
		rd_chk(8'hc8, 32'h0000_0000);
		// Loader path, reserved payload codes kept out
		for (int i = 0; i < 10; i++) begin
			r = $random(seed);
			ld(8'hc4, r);
			if (r[2:0] <= 3'h2)
				cap_exp[2:0] = r[2:0];
			cap_exp[15] = r[15];
			rd_chk(8'hc4, cap_exp);
			chk({29'h0, max_pl}, {29'h0, cap_exp[2:0]});
			chk({29'h0, max_pl_dn}, {29'h0, cap_exp[2:0]});
		end
		// Slot bit load ignored on the upstream port
		ld(8'hc0, 32'hffff_ffff);
		slot_dn = 1'b1;
		rd_chk(8'hc0, hdr_exp);
		// Downstream slot bit cleared by the loader
		ld(8'hc0, 32'h0000_0000);
		slot_dn = 1'b0;
		rd_chk(8'hc0, hdr_exp);
		// Slot power message capture
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			@(posedge clk_in);
			#1;
			spl_v = 1'b1;
			spl_val = r[7:0];
			spl_scl = r[9:8];
			@(posedge clk_in);
			#1;
			spl_v = 1'b0;
			spl_val = ~r[7:0];
			cap_exp[27:18] = r[9:0];
			rd_chk(8'hc4, cap_exp);
		end
		// Second reset restores defaults, other strap level
		@(posedge clk_in);
		#1;
		resetn_in = 1'b0;
		strap = ~strap;
		slot_dn = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		repeat (8) @(posedge clk_in);
		cap_exp = 32'h0000_8000 | (strap ? 32'h2 : 32'h1);
		rd_chk(8'hc4, cap_exp);
		chk({29'h0, max_pl}, {29'h0, cap_exp[2:0]});
		chk({29'h0, max_pl_dn}, {29'h0, cap_exp[2:0]});
		rd_chk(8'hc0, hdr_exp);
		repeat (4) @(posedge clk_in);
		chk(exp_q.size(), 32'h0000_0000);
		chk(exp_dn_q.size(), 32'h0000_0000);
		end_sim();
	end
endmodule
`default_nettype wire
